/* core/clmon_consts.svh */
// constants of the clock loss-of-signal monitor: offsets, fields, resets
// assumes inclusion by bare name from the design file and the testbench
`ifndef CLMON_CONSTS_SVH
`define CLMON_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets on the wishbone slave
// ------------------------------------------------------------------
`define CLMON_ADR_STATUS   8'h00
`define CLMON_ADR_EVENT    8'h04
`define CLMON_ADR_QUAL     8'h08
`define CLMON_ADR_WINDOW   8'h0C
`define CLMON_ADR_THRESH   8'h10
`define CLMON_ADR_NOMINAL  8'h14
`define CLMON_ADR_CONTROL  8'h18

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CLMON_STS_LOS      0
`define CLMON_STS_INVALID  1
`define CLMON_EVT_LOS      0
`define CLMON_QUAL_GOOD    7:4
`define CLMON_QUAL_FAIL    3:0
`define CLMON_WIN_DIV      7:3
`define CLMON_WIN_DISABLE  1
`define CLMON_WIN_MASK     0
`define CLMON_THR_ACC      28:16
`define CLMON_THR_REJ      12:0
`define CLMON_NOM_NUM      12:0
`define CLMON_CTL_SRST     0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CLMON_RST_EVT      1'h1
`define CLMON_RST_LOS      1'h1
`define CLMON_RST_INVALID  1'h1
`define CLMON_RST_SRST     1'h0

`endif

/* core/clmon_pkg.sv */
// types of the clock loss-of-signal monitor
// assumes the constants header sits beside it
package clmon_pkg;

  // ------------------------------------------------------------------
  // qualification state, one-hot; bit 0 is the loss-of-signal level
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOS = 2'h1,
    ST_OK  = 2'h2
  } clmon_state_type;

  // ------------------------------------------------------------------
  // software configuration carried as one word
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  good_times;  // qualification count
    logic [3:0]  fail_times;  // disqualification count
    logic [4:0]  div_ratio;   // monitored clock divide ratio
    logic        ref_dis;     // reference selection disable
    logic        fail_mask;   // exclude status from invalid
    logic [12:0] acc_margin;  // accept margin
    logic [12:0] rej_margin;  // reject margin
    logic [12:0] nom_num;     // nominal window count
  } clmon_cfg_type;

endpackage

/* core/clmon_top.sv */
// loss-of-signal monitor for one reference clock, wishbone classic slave
// assumes one 10 MHz system clock and a monitored clock arriving on a pin
//
// Function
// [RULE1] event flag set while loss reported
// [RULE2] clear write ignored while loss persists
// [RULE3] event flag is one after reset
// [RULE4] enough consecutive accepts qualify, status zero
// [RULE5] enough rejects without qualifying, status one
// [RULE6] count field zero acts as one
// [RULE7] divided monitored clock period is the window
// [RULE8] ratio zero or one divides by one
// [RULE9] software keeps divided clock below sysclk/8
// [RULE10] disable bit forces reference invalid
// [RULE11] disable bit inert on crystal instance
// [RULE12] mask removes status from invalid
// [RULE13] accepted when within nominal plus accept margin
// [RULE14] rejected when outside nominal plus reject margin
// [RULE15] nominal count is expected window length
// [RULE16] nominal zero disables, forces status one
// [RULE17] invalid when unmasked disqualified or disabled
// [RULE18] software holds soft reset while reprogramming
// [RULE19] status reads one after reset
// [RULE20] count system cycles over each window
// [RULE21] in-between window changes nothing
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "clmon_consts.svh"

module clmon_top #(
  parameter bit CRYSTAL_MONITOR_INSTANCE = 1'b0  // instance watches crystal input
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        mon_clk_i,
  input  wire logic        act_disq_i,
  output logic             los_status_o,
  output logic             ref_invalid_o
);

  // ------------------------------------------------------------------
  // state and configuration
  // ------------------------------------------------------------------
  clmon_pkg::clmon_cfg_type   cfg_reg;      // software configuration
  clmon_pkg::clmon_state_type state_reg;    // qualified or lost
  logic                       evt_reg;      // sticky loss event
  logic                       srst_reg;     // monitor soft reset
  logic                       ack_reg;      // bus answer
  logic [31:0]                rdat_reg;     // bus read data
  logic                       inv_reg;      // reference invalid
  logic [2:0]                 sync_reg;     // pin synchroniser
  logic                       lvl_reg;      // filtered monitored level
  logic                       armed_reg;    // first window edge seen
  logic [4:0]                 div_reg;      // edges in current window
  logic [13:0]                cnt_reg;      // system cycles in window
  logic [3:0]                 good_reg;     // consecutive accepts
  logic [3:0]                 fail_reg;     // rejects since qualified
  logic                       first_reg;    // first cycle after reset

  logic        acc_hit;     // access taken this edge
  logic        wr_fire;     // write takes effect this edge
  logic [31:0] be_mask;     // byte lane mask
  logic [31:0] rd_next;     // read mux
  logic        mon_edge;    // rising edge of monitored clock
  logic [4:0]  ratio_eff;   // effective divide ratio
  logic [3:0]  good_eff;    // effective qualification count
  logic [3:0]  fail_eff;    // effective disqualification count
  logic        win_end;     // window boundary
  logic        timeout;     // window overran the reject band
  logic        eval_val;    // a window result is ready
  logic [13:0] diff;        // distance from nominal
  logic        is_acc;      // accepted window
  logic        is_rej;      // rejected window
  logic        dis_eff;     // disable after instance gating
  logic        evt_clr;     // software one written to event bit

  // ------------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, write on the ack edge
  // ------------------------------------------------------------------
  assign acc_hit = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

  // byte lane mask from the selects
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign be_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (wb_adr_i)
      `CLMON_ADR_STATUS: begin
        rd_next[`CLMON_STS_LOS]     = state_reg[0];
        rd_next[`CLMON_STS_INVALID] = inv_reg;
      end
      `CLMON_ADR_EVENT:   rd_next[`CLMON_EVT_LOS] = evt_reg;
      `CLMON_ADR_QUAL: begin
        rd_next[`CLMON_QUAL_GOOD] = cfg_reg.good_times;
        rd_next[`CLMON_QUAL_FAIL] = cfg_reg.fail_times;
      end
      `CLMON_ADR_WINDOW: begin
        rd_next[`CLMON_WIN_DIV]     = cfg_reg.div_ratio;
        rd_next[`CLMON_WIN_DISABLE] = cfg_reg.ref_dis;
        rd_next[`CLMON_WIN_MASK]    = cfg_reg.fail_mask;
      end
      `CLMON_ADR_THRESH: begin
        rd_next[`CLMON_THR_ACC] = cfg_reg.acc_margin;
        rd_next[`CLMON_THR_REJ] = cfg_reg.rej_margin;
      end
      `CLMON_ADR_NOMINAL: rd_next[`CLMON_NOM_NUM] = cfg_reg.nom_num;
      `CLMON_ADR_CONTROL: rd_next[`CLMON_CTL_SRST] = srst_reg;
      default:            rd_next = 32'h0000_0000;
    endcase
  end

  // answer and read data
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc_hit;
      if (acc_hit) begin
        rdat_reg <= rd_next;
      end
    end
  end

  // configuration writes, byte lanes honoured
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg  <= '0;
      srst_reg <= `CLMON_RST_SRST;
    end else if (wr_fire) begin
      case (wb_adr_i)
        `CLMON_ADR_QUAL: if (wb_sel_i[0]) begin
          cfg_reg.good_times <= wb_dat_i[`CLMON_QUAL_GOOD];
          cfg_reg.fail_times <= wb_dat_i[`CLMON_QUAL_FAIL];
        end
        `CLMON_ADR_WINDOW: if (wb_sel_i[0]) begin
          cfg_reg.div_ratio <= wb_dat_i[`CLMON_WIN_DIV];
          cfg_reg.ref_dis   <= wb_dat_i[`CLMON_WIN_DISABLE];
          cfg_reg.fail_mask <= wb_dat_i[`CLMON_WIN_MASK];
        end
        `CLMON_ADR_THRESH: begin
          cfg_reg.acc_margin <= (cfg_reg.acc_margin & ~be_mask[`CLMON_THR_ACC])
                              | (wb_dat_i[`CLMON_THR_ACC] & be_mask[`CLMON_THR_ACC]);
          cfg_reg.rej_margin <= (cfg_reg.rej_margin & ~be_mask[`CLMON_THR_REJ])
                              | (wb_dat_i[`CLMON_THR_REJ] & be_mask[`CLMON_THR_REJ]);
        end
        `CLMON_ADR_NOMINAL: begin
          cfg_reg.nom_num <= (cfg_reg.nom_num & ~be_mask[`CLMON_NOM_NUM])
                           | (wb_dat_i[`CLMON_NOM_NUM] & be_mask[`CLMON_NOM_NUM]);
        end
        `CLMON_ADR_CONTROL: if (wb_sel_i[0]) begin
          srst_reg <= wb_dat_i[`CLMON_CTL_SRST];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sticky event flag: set wins over the one-to-clear
  // ------------------------------------------------------------------
  assign evt_clr = wr_fire && (wb_adr_i == `CLMON_ADR_EVENT) && wb_sel_i[0]
                   && wb_dat_i[`CLMON_EVT_LOS];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_reg <= `CLMON_RST_EVT;                       // [RULE3]
    end else begin
      evt_reg <= state_reg[0] || (evt_reg && !evt_clr); // [RULE1] [RULE2]
    end
  end

  // ------------------------------------------------------------------
  // monitored clock: three flops, level moves when second and third agree
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_reg <= 3'h0;
      lvl_reg  <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], mon_clk_i};
      if (sync_reg[1] == sync_reg[2]) begin
        lvl_reg <= sync_reg[2];
      end
    end
  end

  assign mon_edge = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !lvl_reg;

  // ------------------------------------------------------------------
  // window formation and measurement
  // ------------------------------------------------------------------
  assign ratio_eff = (cfg_reg.div_ratio <= 5'h01) ? 5'h01 : cfg_reg.div_ratio; // [RULE8]
  assign good_eff  = (cfg_reg.good_times == 4'h0) ? 4'h1 : cfg_reg.good_times; // [RULE6]
  assign fail_eff  = (cfg_reg.fail_times == 4'h0) ? 4'h1 : cfg_reg.fail_times; // [RULE6]
  // window closes after ratio monitored edges
  assign win_end   = armed_reg && mon_edge && (div_reg == ratio_eff - 5'h01); // [RULE7]
  // a dead clock never closes a window, so overrun is judged a reject
  assign timeout   = armed_reg && !win_end
                     && ({1'b0, cnt_reg} > ({2'b00, cfg_reg.nom_num}
                                          + {2'b00, cfg_reg.rej_margin}));
  assign eval_val  = win_end || timeout;
  assign diff      = (cnt_reg >= {1'b0, cfg_reg.nom_num})
                     ? cnt_reg - {1'b0, cfg_reg.nom_num}
                     : {1'b0, cfg_reg.nom_num} - cnt_reg;                     // [RULE15]
  assign is_acc    = win_end && (diff <= {1'b0, cfg_reg.acc_margin});        // [RULE13]
  assign is_rej    = timeout || (win_end && !is_acc
                                 && (diff > {1'b0, cfg_reg.rej_margin}));     // [RULE14]

  // edge and cycle counters, held idle by the soft reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_reg <= 1'b0;
      div_reg   <= 5'h00;
      cnt_reg   <= 14'h0000;
    end else if (srst_reg || cfg_reg.nom_num == 13'h0000) begin
      armed_reg <= 1'b0;
      div_reg   <= 5'h00;
      cnt_reg   <= 14'h0000;
    end else if (!armed_reg) begin
      if (mon_edge) begin
        armed_reg <= 1'b1;
        cnt_reg   <= 14'h0001;
      end
    end else if (eval_val) begin
      div_reg <= 5'h00;
      cnt_reg <= 14'h0001;                                       // [RULE20]
    end else begin
      if (mon_edge) begin
        div_reg <= div_reg + 5'h01;
      end
      if (cnt_reg != 14'h3FFF) begin
        cnt_reg <= cnt_reg + 14'h0001;                           // [RULE20]
      end
    end
  end

  // ------------------------------------------------------------------
  // qualification state machine and tallies
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= clmon_pkg::ST_LOS;                            // [RULE19]
      good_reg  <= 4'h0;
      fail_reg  <= 4'h0;
    end else if (srst_reg || cfg_reg.nom_num == 13'h0000) begin
      state_reg <= clmon_pkg::ST_LOS;                            // [RULE16]
      good_reg  <= 4'h0;
      fail_reg  <= 4'h0;
    end else if (is_acc) begin
      if ({1'b0, good_reg} + 5'h01 >= {1'b0, good_eff}) begin
        state_reg <= clmon_pkg::ST_OK;                           // [RULE4]
        good_reg  <= 4'h0;
        fail_reg  <= 4'h0;
      end else begin
        good_reg <= good_reg + 4'h1;
      end
    end else if (is_rej) begin
      good_reg <= 4'h0;
      if ({1'b0, fail_reg} + 5'h01 >= {1'b0, fail_eff}) begin
        state_reg <= clmon_pkg::ST_LOS;                          // [RULE5]
        fail_reg  <= 4'h0;
      end else begin
        fail_reg <= fail_reg + 4'h1;
      end
    end else begin
      case (state_reg)
        clmon_pkg::ST_LOS: state_reg <= clmon_pkg::ST_LOS;       // [RULE21]
        clmon_pkg::ST_OK:  state_reg <= clmon_pkg::ST_OK;
        default:           state_reg <= clmon_pkg::ST_LOS;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // reference invalid toward the selector
  // ------------------------------------------------------------------
  assign dis_eff = cfg_reg.ref_dis && !CRYSTAL_MONITOR_INSTANCE;  // [RULE11]

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inv_reg <= `CLMON_RST_INVALID;
    end else begin
      inv_reg <= dis_eff                                          // [RULE10]
                 || act_disq_i                                    // [RULE17]
                 || (state_reg[0] && !cfg_reg.fail_mask);         // [RULE12]
    end
  end

  // first cycle after reset, for checking only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = rdat_reg;
  assign los_status_o  = state_reg[0];
  assign ref_invalid_o = inv_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_evt_set; los_status_o |=> evt_reg; endproperty
  a_evt_set: assert property (p_evt_set) else $error("event not set on loss"); // [RULE1]

  property p_clr_block; (evt_clr && los_status_o) |=> evt_reg; endproperty
  a_clr_block: assert property (p_clr_block) else $error("event cleared in loss"); // [RULE2]

  property p_reset_vals; first_reg |-> evt_reg && los_status_o && ref_invalid_o; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // [RULE3]

  property p_qualify;
    (is_acc && !srst_reg && cfg_reg.nom_num != 13'h0000
     && {1'b0, good_reg} + 5'h01 >= {1'b0, good_eff}) |=> !los_status_o;
  endproperty
  a_qualify: assert property (p_qualify) else $error("clock not qualified"); // [RULE4]

  property p_disq;
    (is_rej && !srst_reg && {1'b0, fail_reg} + 5'h01 >= {1'b0, fail_eff}) |=> los_status_o;
  endproperty
  a_disq: assert property (p_disq) else $error("clock not disqualified"); // [RULE5]

  property p_zero_one;
    (cfg_reg.fail_times == 4'h0 && is_rej && !srst_reg) |=> los_status_o;
  endproperty
  a_zero_one: assert property (p_zero_one) else $error("zero count not one"); // [RULE6]

  property p_disable; dis_eff |=> ref_invalid_o; endproperty
  a_disable: assert property (p_disable) else $error("disable ignored"); // [RULE10]

  property p_mask;
    (cfg_reg.fail_mask && !dis_eff && !act_disq_i) |=> !ref_invalid_o;
  endproperty
  a_mask: assert property (p_mask) else $error("mask ignored"); // [RULE12]

  property p_nom_zero; (cfg_reg.nom_num == 13'h0000) |=> los_status_o; endproperty
  a_nom_zero: assert property (p_nom_zero) else $error("zero nominal not lost"); // [RULE16]

  property p_between;
    (eval_val && !is_acc && !is_rej && !srst_reg && cfg_reg.nom_num != 13'h0000)
      |=> $stable(good_reg) && $stable(fail_reg) && $stable(state_reg);
  endproperty
  a_between: assert property (p_between) else $error("in-between window acted"); // [RULE21]

endmodule // clmon_top

/* testbench/clmon_ref_model.sv */
// monitored reference clock source for the loss-of-signal monitor bench
// assumes the bench sets the period in ns; zero stops the clock
`timescale 1ns/1ps

module clmon_ref_model (
  input  wire logic [31:0] period_ns_i,  // full period in ns, 0 = dead clock
  output logic             mon_clk_o     // monitored clock toward the pin
);
  // ------------------------------------------------------------------
  // clock generation, phase unrelated to the system clock
  // ------------------------------------------------------------------
  // the bench only asks for periods whose divided clock stays below sysclk/8
  initial begin
    mon_clk_o = 1'b0;
    #13;
    forever begin
      if (period_ns_i == 0) begin
        #50;  // stopped: line stands at its last level
      end else begin
        #(period_ns_i / 2) mon_clk_o = ~mon_clk_o;
      end
    end
  end
endmodule // clmon_ref_model

/* testbench/tb_clock_loss_of_signal_monitor.sv */
// self-checking bench of the loss-of-signal monitor over wishbone
// assumes the constants header on the include path and the clock model
`timescale 1ns/1ps
`include "clmon_consts.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_clock_loss_of_signal_monitor;
  typedef struct packed {
    logic [7:0]  adr;  // address read
    logic [31:0] val;  // expected read data
  } clmon_note_type;

  logic        clk_i     = 1'b0;  // system clock
  logic        nrst_i    = 1'b0;  // reset, active low
  logic        wb_cyc    = 1'b0;  // bus cycle
  logic        wb_stb    = 1'b0;  // bus strobe
  logic        wb_we     = 1'b0;  // write enable
  logic [7:0]  wb_adr    = 8'h00; // byte address
  logic [31:0] wb_wdat   = 32'h0000_0000;
  logic [31:0] wb_dat_o;          // read data
  logic        wb_ack_o;          // acknowledge
  logic        mon_clk;           // monitored clock
  logic        act_disq  = 1'b0;  // activity monitor verdict
  logic        los_status_o;
  logic        ref_invalid_o;
  logic        x_inv;             // crystal instance reference invalid
  logic        dis_set   = 1'b0;  // bench has written the disable bit
  int          period_ns = 0;     // monitored clock period
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  logic [31:0] seed = 32'h0000_e4f9;  // random source state
  clmon_note_type notes[$];       // expected read results

  // ------------------------------------------------------------------
  // clock, device and far side
  // ------------------------------------------------------------------
  always #50 clk_i = ~clk_i;

  clmon_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_clk_i(mon_clk), .act_disq_i(act_disq),
    .los_status_o(los_status_o), .ref_invalid_o(ref_invalid_o));

  // same bus and pins, but watching the crystal input: disable bit inert
  clmon_top #(.CRYSTAL_MONITOR_INSTANCE(1'b1)) u_xtal (.clk_i(clk_i), .nrst_i(nrst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(), .wb_ack_o(), .mon_clk_i(mon_clk),
    .act_disq_i(act_disq), .los_status_o(), .ref_invalid_o(x_inv));

  clmon_ref_model u_ref (.period_ns_i(period_ns), .mon_clk_o(mon_clk));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // classic single cycle, held until ack is sampled, then one idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{adr: a, val: e});
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  // ------------------------------------------------------------------
  // result watcher: oldest note against each read answer
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
      clmon_note_type n;
      n = notes.pop_front();
      `CHK("read data", n.val, wb_dat_o)
      if (n.adr == `CLMON_ADR_STATUS) begin
        `CHK("status pins", n.val[1:0], {ref_invalid_o, los_status_o})
        `CHK("crystal invalid", n.val[1] & ~dis_set, x_inv)
      end
    end
  end

  // ------------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    cyc(20);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    rd(`CLMON_ADR_EVENT, 32'h0000_0001);
    rd(`CLMON_ADR_QUAL, 32'h0000_0000);
    rd(`CLMON_ADR_WINDOW, 32'h0000_0000);
    rd(`CLMON_ADR_THRESH, 32'h0000_0000);
    rd(`CLMON_ADR_NOMINAL, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    wr(`CLMON_ADR_EVENT, 32'h0000_0001);
    rd(`CLMON_ADR_EVENT, 32'h0000_0001);
    // random register contents, monitor held in soft reset
    wr(`CLMON_ADR_CONTROL, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`CLMON_ADR_QUAL, seed);
      rd(`CLMON_ADR_QUAL, seed & 32'h0000_00FF);
      wr(`CLMON_ADR_THRESH, seed);
      rd(`CLMON_ADR_THRESH, seed & 32'h1FFF_1FFF);
      wr(`CLMON_ADR_NOMINAL, seed);
      rd(`CLMON_ADR_NOMINAL, seed & 32'h0000_1FFF);
      wr(`CLMON_ADR_WINDOW, seed & 32'h0000_0073);  // ratio kept off all ones
      rd(`CLMON_ADR_WINDOW, seed & 32'h0000_0073);
    end
    // nominal 12, accept 1, reject 3, two accepts qualify
    wr(`CLMON_ADR_QUAL, 32'h0000_0020);
    wr(`CLMON_ADR_WINDOW, 32'h0000_0000);
    wr(`CLMON_ADR_THRESH, 32'h0001_0003);
    wr(`CLMON_ADR_NOMINAL, 32'h0000_000C);
    period_ns = 1200;
    wr(`CLMON_ADR_CONTROL, 32'h0000_0000);
    cyc(150);
    rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    wr(`CLMON_ADR_EVENT, 32'h0000_0001);
    rd(`CLMON_ADR_EVENT, 32'h0000_0000);
    // divided clock forms the window
    for (int r = 1; r <= 3; r++) begin
      wr(`CLMON_ADR_WINDOW, 32'(r) << 3);
      period_ns = 1200 / r;
      cyc(200);
      rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    end
    // window between margins changes nothing
    wr(`CLMON_ADR_WINDOW, 32'h0000_0000);
    period_ns = 1200;
    cyc(100);
    period_ns = 1400;
    cyc(150);
    rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    // fail count zero acts as one
    period_ns = 0;
    cyc(40);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    period_ns = 1200;
    cyc(100);
    rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    // three rejects needed
    wr(`CLMON_ADR_QUAL, 32'h0000_0023);
    period_ns = 0;
    cyc(25);
    rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    cyc(80);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    wr(`CLMON_ADR_EVENT, 32'h0000_0001);
    rd(`CLMON_ADR_EVENT, 32'h0000_0001);
    // mask, disable and activity verdict
    wr(`CLMON_ADR_WINDOW, 32'h0000_0001);
    rd(`CLMON_ADR_STATUS, 32'h0000_0001);
    dis_set = 1'b1;
    wr(`CLMON_ADR_WINDOW, 32'h0000_0003);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    dis_set = 1'b0;
    wr(`CLMON_ADR_WINDOW, 32'h0000_0001);
    act_disq <= 1'b1;
    cyc(2);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    act_disq <= 1'b0;
    // nominal zero switches the monitor off
    wr(`CLMON_ADR_WINDOW, 32'h0000_0000);
    period_ns = 1200;
    cyc(120);
    rd(`CLMON_ADR_STATUS, 32'h0000_0000);
    wr(`CLMON_ADR_WINDOW, 32'h0000_0001);  // mask set before nominal zero
    wr(`CLMON_ADR_NOMINAL, 32'h0000_0000);
    cyc(5);
    rd(`CLMON_ADR_STATUS, 32'h0000_0001);
    // second reset in mid-run
    nrst_i <= 1'b0;
    cyc(3);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(`CLMON_ADR_STATUS, 32'h0000_0003);
    rd(`CLMON_ADR_EVENT, 32'h0000_0001);
    end_sim();
  end
endmodule // tb_clock_loss_of_signal_monitor
